// ===== rtl/scdbp_top.sv
// single-cycle data break port: steals processor cycles for device memory access
`timescale 1ns/1ns
module scdbp_top #(
   parameter int BUF_DEPTH = 2
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [scdbp_pkg::WORD_W-1:0] target_addr_n_i,
   input wire logic [scdbp_pkg::WORD_W-1:0] inbound_word_n_i,
   input wire logic xfer_dir_i,
   input wire logic cycle_kind_i,
   input wire logic bump_word_request_n_i,
   input wire logic steal_req_i,
   input wire logic insn_boundary_i,
   input wire logic [scdbp_pkg::WORD_W-1:0] mem_rdata_i,
   input wire logic out_ready_i,
   output logic [scdbp_pkg::WORD_W-1:0] core_address_latch_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic [scdbp_pkg::WORD_W-1:0] mem_wdata_o,
   output logic [scdbp_pkg::WORD_W-1:0] core_word_latch_o,
   output logic addr_accepted_o,
   output logic steal_active_o,
   output logic cpu_hold_o,
   output logic word_tally_req_o,
   output logic phase_one_pulse_o,
   output logic phase_two_pulse_o,
   output logic phase_three_pulse_o,
   output logic buffered_slot_two_pulse_o,
   output logic buffered_slot_five_pulse_o,
   output logic out_valid_o,
   output logic [scdbp_pkg::WORD_W-1:0] out_word_o
);
   import scdbp_pkg::*;

   scdbp_buf_if #(.W(WORD_W)) buf_if ();

   logic [PIN_W-1:0] sync1_r, sync2_r, sync3_r, pin_r, pin_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt, gap_r, gap_nxt;
   logic ph1, ph2, ph3, slot5, wr_t;
   logic [WORD_W-1:0] addr_s, data_s;
   logic dir_s, kind_s, bump_s, req_s, start_ok;
   scdbp_state_t state_r, state_nxt;
   logic again_r, again_nxt;
   logic [WORD_W-1:0] mal_r, mal_nxt, mwl_r, mwl_nxt, wdat_r, wdat_nxt;
   logic ack_r, ack_nxt, rd_r, rd_nxt, wr_r, wr_nxt, push_r, push_nxt;
   logic p1_r, p2_r, p3_r, p5_r;

   // pin levels: three stages, a change counts once stages two and three agree
   always_comb begin
      pin_nxt = (~(sync2_r ^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & pin_r);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= PIN_RST;
         sync2_r <= PIN_RST;
         sync3_r <= PIN_RST;
         pin_r <= PIN_RST;
      end else begin
         sync1_r <= {steal_req_i, bump_word_request_n_i, cycle_kind_i, xfer_dir_i,
                     inbound_word_n_i, target_addr_n_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         pin_r <= pin_nxt;
      end
   end

   // ground-true address and data pins turned to positive words
   assign addr_s = ~pin_r[PIN_ADDR_LSB +: WORD_W];
   assign data_s = ~pin_r[PIN_DATA_LSB +: WORD_W];
   assign dir_s = pin_r[PIN_DIR_BIT];
   assign kind_s = pin_r[PIN_KIND_BIT];
   assign bump_s = ~pin_r[PIN_BUMP_BIT];
   assign req_s = pin_r[PIN_REQ_BIT];

   // processor cycle counter and time pulse decode
   assign ph1 = (cnt_r == PH1_CNT);
   assign ph2 = (cnt_r == PH2_CNT);
   assign ph3 = (cnt_r == PH3_CNT);
   assign slot5 = (cnt_r == SLOT5_CNT);
   assign wr_t = (cnt_r == WR_CNT);

   // cycle counter and throughput spacing counter
   always_comb begin
      cnt_nxt = (cnt_r == LAST_CNT) ? CNT_RST : CNT_W'(cnt_r + 1'b1);
      gap_nxt = (gap_r == CNT_RST) ? CNT_RST : CNT_W'(gap_r - 1'b1);
      if (ph1 && start_ok) begin
         gap_nxt = GAP_LOAD;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= CNT_RST;
         gap_r <= CNT_RST;
      end else begin
         cnt_r <= cnt_nxt;
         gap_r <= gap_nxt;
      end
   end

   // a steal opens only at an instruction boundary or as a held follow-on,
   // in single-cycle kind, past the rate gap, with buffer room for output
   assign start_ok = req_s && kind_s
                  && (insn_boundary_i || (state_r == ST_STEAL && again_r))
                  && (gap_r == CNT_RST)
                  && (dir_s || buf_if.in_ready);

   // steal sequencer and core access next values
   always_comb begin
      state_nxt = state_r;
      again_nxt = again_r;
      mal_nxt = mal_r;
      mwl_nxt = mwl_r;
      wdat_nxt = wdat_r;
      ack_nxt = 1'b0;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      push_nxt = 1'b0;
      unique case (state_r)
         ST_RUN: begin
            if (ph1 && start_ok) begin
               state_nxt = ST_STEAL;
               ack_nxt = 1'b1;
               mal_nxt = addr_s;
               rd_nxt = 1'b1;
               again_nxt = 1'b0;
            end
         end
         ST_STEAL: begin
            if (ph1) begin
               again_nxt = 1'b0;
               if (start_ok) begin
                  ack_nxt = 1'b1;
                  mal_nxt = addr_s;
                  rd_nxt = 1'b1;
               end else begin
                  state_nxt = ST_RUN;
               end
            end
            if (ph2) begin
               again_nxt = req_s;
            end
            if (ph3) begin
               // word latch moves only here; carry forced for increments
               if (dir_s) begin
                  mwl_nxt = data_s;
               end else if (bump_s) begin
                  mwl_nxt = WORD_W'(mem_rdata_i + 1'b1);
               end else begin
                  mwl_nxt = mem_rdata_i;
                  push_nxt = 1'b1;
               end
            end
            if (wr_t) begin
               wr_nxt = 1'b1;
               wdat_nxt = mwl_r;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_RUN;
         again_r <= 1'b0;
         mal_r <= WORD_RST;
         mwl_r <= WORD_RST;
         wdat_r <= WORD_RST;
         ack_r <= 1'b0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         push_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         again_r <= again_nxt;
         mal_r <= mal_nxt;
         mwl_r <= mwl_nxt;
         wdat_r <= wdat_nxt;
         ack_r <= ack_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         push_r <= push_nxt;
      end
   end

   // registered time pulses toward the device
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p1_r <= 1'b0;
         p2_r <= 1'b0;
         p3_r <= 1'b0;
         p5_r <= 1'b0;
      end else begin
         p1_r <= ph1;
         p2_r <= ph2;
         p3_r <= ph3;
         p5_r <= slot5;
      end
   end

   // outbound words queue so a stalled receiver loses none
   assign buf_if.in_valid = push_r;
   assign buf_if.in_data = mwl_r;
   assign buf_if.out_ready = out_ready_i;

   scdbp_buf #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .bus(buf_if)
   );

   // output drive
   assign core_address_latch_o = mal_r;
   assign mem_rd_o = rd_r;
   assign mem_wr_o = wr_r;
   assign mem_wdata_o = wdat_r;
   assign core_word_latch_o = mwl_r;
   assign addr_accepted_o = ack_r;
   assign steal_active_o = (state_r == ST_STEAL);
   assign cpu_hold_o = (state_r == ST_STEAL);
   assign word_tally_req_o = req_s && !kind_s;
   assign phase_one_pulse_o = p1_r;
   assign phase_two_pulse_o = p2_r;
   assign phase_three_pulse_o = p3_r;
   assign buffered_slot_two_pulse_o = p2_r;
   assign buffered_slot_five_pulse_o = p5_r;
   assign out_valid_o = buf_if.out_valid;
   assign out_word_o = buf_if.out_data;

   // helper for the rate check: cycles since the last acknowledge
   logic [CNT_W:0] since_r;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         since_r <= '1;
      end else if (ack_r) begin
         since_r <= (CNT_W+1)'(1);
      end else if (since_r != '1) begin
         since_r <= (CNT_W+1)'(since_r + 1'b1);
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_ack_first_pulse: assert property (addr_accepted_o |-> phase_one_pulse_o && steal_active_o)
      else $error("acknowledge outside first pulse of steal");
   a_addr_latched: assert property (addr_accepted_o |-> core_address_latch_o == $past(addr_s))
      else $error("address not latched at first pulse");
   a_read_by_three: assert property (mem_rd_o |-> ##225 phase_three_pulse_o)
      else $error("word latch not loaded by third pulse");
   a_latch_only_tp3: assert property ($changed(core_word_latch_o) |-> phase_three_pulse_o)
      else $error("word latch moved away from third pulse");
   a_bump_carry: assert property (steal_active_o && ph3 && !dir_s && bump_s
      |=> core_word_latch_o == WORD_W'($past(mem_rdata_i) + 1'b1))
      else $error("increment carry missing");
   a_rewrite_same: assert property (mem_wr_o |-> steal_active_o
      && mem_wdata_o == core_word_latch_o && $stable(core_address_latch_o))
      else $error("rewrite data or address wrong");
   a_rate_gap: assert property (addr_accepted_o |-> $past(since_r) >= 462)
      else $error("steal rate ceiling exceeded");
   a_drop_resumes: assert property (steal_active_o && ph1 && !again_r
      |=> !steal_active_o)
      else $error("steal continued after request drop");
   a_hold_steal: assert property ($rose(cpu_hold_o) |-> addr_accepted_o)
      else $error("processor held without an acknowledge");
   // a steal is only ever opened for the single-cycle kind
   a_kind_single: assert property (addr_accepted_o |-> $past(kind_s))
      else $error("steal opened for three-cycle kind");
   a_push_output: assert property (buf_if.in_valid
      |-> steal_active_o && !dir_s && !bump_s)
      else $error("word queued outside a plain output steal");
   a_ack_single: assert property (addr_accepted_o |=> !addr_accepted_o)
      else $error("acknowledge longer than one cycle");
   a_rewrite_once: assert property (mem_wr_o |=> !mem_wr_o)
      else $error("rewrite strobe longer than one cycle");
endmodule

// ===== rtl/scdbp_pkg.sv
// shared constants and types for the cycle-stealing data port
package scdbp_pkg;
   // word and pin bundle geometry
   localparam int WORD_W = 12;
   localparam int PIN_W = 28;
   localparam int PIN_ADDR_LSB = 0;
   localparam int PIN_DATA_LSB = 12;
   localparam int PIN_DIR_BIT = 24;
   localparam int PIN_KIND_BIT = 25;
   localparam int PIN_BUMP_BIT = 26;
   localparam int PIN_REQ_BIT = 27;
   // clock and processor cycle timing
   localparam int CLK_NS = 4;
   localparam int CYCLE_NS = 1600;
   localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
   localparam int PH2_NS = 400;
   localparam int PH3_NS = 900;
   localparam int SLOT5_NS = 1200;
   localparam int WR_NS = 1300;
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] PH1_CNT = 9'h000;
   localparam logic [CNT_W-1:0] PH2_CNT = CNT_W'(PH2_NS / CLK_NS);
   localparam logic [CNT_W-1:0] PH3_CNT = CNT_W'(PH3_NS / CLK_NS);
   localparam logic [CNT_W-1:0] SLOT5_CNT = CNT_W'(SLOT5_NS / CLK_NS);
   localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_NS / CLK_NS);
   localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(CYCLE_CLKS - 1);
   // throughput ceiling: 6.5 Mbit/s, given in tenths of Mbit/s
   localparam int RATE_X10 = 65;
   localparam int GAP_CLKS = (WORD_W * 10000 + RATE_X10 * CLK_NS - 1) / (RATE_X10 * CLK_NS);
   localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CLKS - 1);
   // values after reset
   localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
   localparam logic [PIN_W-1:0] PIN_RST = 28'h0000000;
   localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
   // steal sequencer states
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_STEAL = 2'b10
   } scdbp_state_t;
endpackage

// ===== rtl/scdbp_buf_if.sv
// valid/ready carrier between the port and its outbound word buffer
`timescale 1ns/1ns
interface scdbp_buf_if #(parameter int W = 12);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport src (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// ===== rtl/scdbp_buf.sv
// small circular buffer holding outbound words toward the device
`timescale 1ns/1ns
module scdbp_buf #(
   parameter int W = 12,
   parameter int DEPTH = 2
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   scdbp_buf_if.fifo bus
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [W-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic push, pop;

   // honest full and empty from the occupancy count
   assign bus.in_ready = (cnt_r != CW'(DEPTH));
   assign bus.out_valid = (cnt_r != '0);
   assign bus.out_data = mem_r[rp_r];
   assign push = bus.in_valid && bus.in_ready;
   assign pop = bus.out_valid && bus.out_ready;

   // pointer and count next values
   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : PW'(wp_r + 1'b1);
      end
      if (pop) begin
         rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : PW'(rp_r + 1'b1);
      end
      if (push && !pop) begin
         cnt_nxt = CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
         cnt_nxt = CW'(cnt_r - 1'b1);
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage, one register per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            mem_r[i] <= '0;
         end else if (push && (wp_r == PW'(i))) begin
            mem_r[i] <= bus.in_data;
         end
      end
   end
endmodule

// ===== verif/scdbp_dev_model.sv
// device-side model: ground-true levels, steal requests and the outbound strobe
`timescale 1ns/1ns
module scdbp_dev_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic go_i,
   input wire logic stop_i,
   input wire logic hold_i,
   input wire logic [11:0] addr_i,
   input wire logic [11:0] data_i,
   input wire logic dir_i,
   input wire logic kind_i,
   input wire logic bump_i,
   input wire logic ack_i,
   input wire logic act_i,
   input wire logic slot2_i,
   input wire logic slot5_i,
   input wire logic [11:0] word_i,
   output logic [11:0] addr_n_o,
   output logic [11:0] data_n_o,
   output logic dir_o,
   output logic kind_o,
   output logic bump_n_o,
   output logic req_o,
   output logic [11:0] capt_o,
   output int capt_cnt_o
);
   logic [11:0] a_r;
   logic [11:0] w_r;
   logic rel_r;
   logic arm_r;
   logic win_r;
   logic act_r;
   // released lines show the inverse of the last level driven
   assign addr_n_o = rel_r ? a_r : ~a_r;
   assign data_n_o = rel_r ? w_r : ~w_r;
   assign capt_o = w_r;
   // levels first, request one cycle later; strobe only inside the window
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_r <= 12'h000;
         w_r <= 12'h000;
         rel_r <= 1'b1;
         arm_r <= 1'b0;
         win_r <= 1'b0;
         act_r <= 1'b0;
         dir_o <= 1'b0;
         kind_o <= 1'b1;
         bump_n_o <= 1'b1;
         req_o <= 1'b0;
         capt_cnt_o <= 0;
      end else begin
         act_r <= act_i;
         arm_r <= go_i;
         if (go_i) begin
            a_r <= addr_i;
            w_r <= data_i;
            dir_o <= dir_i;
            kind_o <= kind_i;
            bump_n_o <= ~bump_i;
            rel_r <= 1'b0;
         end
         if (arm_r)
            req_o <= 1'b1;
         if (ack_i) begin
            a_r <= a_r + 12'h001;
            req_o <= req_o & hold_i;
         end
         if (stop_i)
            req_o <= 1'b0;
         if (act_r && !act_i && !req_o)
            rel_r <= 1'b1;
         if (slot5_i)
            win_r <= act_i & ~dir_o & bump_n_o;
         if (slot2_i && win_r) begin
            w_r <= word_i;
            capt_cnt_o <= capt_cnt_o + 1;
         end
      end
   end
endmodule

// ===== verif/testbench.sv
// self-checking bench for the cycle-stealing data port
`timescale 1ns/1ns
module testbench;
   import scdbp_pkg::*;
   logic core_clk_i, rst_n_i, insn_b, rdy, go, stop, hold, dir, kind, bump;
   logic [11:0] addr, data, rdata;
   logic [11:0] mem [0:4095];
   logic [11:0] a_n, d_n, cal, wd, cwl, ow, capt;
   logic d_dir, d_kind, d_bump_n, d_req, wr, ack, act, tally, p3, b2, b5, ov;
   logic rd, p1, p2, cpu_hold;
   int capt_cnt, cbase, n, num_errors, total_checks;
   scdbp_top #(.BUF_DEPTH(2)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .target_addr_n_i(a_n), .inbound_word_n_i(d_n), .xfer_dir_i(d_dir),
      .cycle_kind_i(d_kind), .bump_word_request_n_i(d_bump_n), .steal_req_i(d_req),
      .insn_boundary_i(insn_b), .mem_rdata_i(rdata), .out_ready_i(rdy),
      .core_address_latch_o(cal), .mem_rd_o(rd), .mem_wr_o(wr), .mem_wdata_o(wd),
      .core_word_latch_o(cwl), .addr_accepted_o(ack), .steal_active_o(act),
      .cpu_hold_o(cpu_hold), .word_tally_req_o(tally), .phase_one_pulse_o(p1),
      .phase_two_pulse_o(p2), .phase_three_pulse_o(p3), .buffered_slot_two_pulse_o(b2),
      .buffered_slot_five_pulse_o(b5), .out_valid_o(ov), .out_word_o(ow));
   scdbp_dev_model i_dev (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .go_i(go),
      .stop_i(stop), .hold_i(hold), .addr_i(addr), .data_i(data), .dir_i(dir),
      .kind_i(kind), .bump_i(bump), .ack_i(ack), .act_i(act), .slot2_i(b2),
      .slot5_i(b5), .word_i(cwl), .addr_n_o(a_n), .data_n_o(d_n), .dir_o(d_dir),
      .kind_o(d_kind), .bump_n_o(d_bump_n), .req_o(d_req), .capt_o(capt),
      .capt_cnt_o(capt_cnt));
   // clock generator
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   // core memory: read data follows the latched address, rewrite on strobe
   always @(posedge core_clk_i) begin
      rdata <= mem[cal];
      if (wr === 1'b1)
         mem[cal] <= wd;
   end
   task automatic tally_res(input bit ok, input string m);
      total_checks++;
      if (!ok) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic chk_w(input logic [11:0] got, input logic [11:0] exp);
      tally_res(got === exp, $sformatf("word %h expected %h", got, exp));
   endtask
   task automatic chk_b(input logic got, input logic exp);
      tally_res(got === exp, $sformatf("flag %b expected %b", got, exp));
   endtask
   task automatic chk_n(input int got, input int exp);
      tally_res(got == exp, $sformatf("count %0d expected %0d", got, exp));
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic probe(input int s);
      case (s)
         0: return ack;
         1: return p3;
         2: return ~act;
         3: return capt_cnt > cbase;
         5: return p2;
         default: return tally;
      endcase
   endfunction
   // bounded wait on a probe, counting negative edges
   task automatic await(input int s, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(negedge core_clk_i);
         cnt++;
      end while (probe(s) !== 1'b1 && cnt < lim);
      if (probe(s) !== 1'b1) begin
         num_errors++;
         $display("mismatch at %0t: wait %0d ran out", $time, s);
         close_out();
      end
   endtask
   // no acknowledge may appear for lim cycles
   task automatic quiet(input int lim);
      logic seen;
      seen = 1'b0;
      repeat (lim) begin
         @(negedge core_clk_i);
         seen = seen | (ack === 1'b1);
      end
      chk_b(seen, 1'b0);
   endtask
   task automatic issue(input logic [11:0] a, d, input logic dir_v, k, bp, h);
      @(posedge core_clk_i);
      addr <= a;
      data <= d;
      dir <= dir_v;
      kind <= k;
      bump <= bp;
      hold <= h;
      go <= 1'b1;
      @(posedge core_clk_i);
      go <= 1'b0;
   endtask
   task automatic pulse_stop;
      @(posedge core_clk_i);
      stop <= 1'b1;
      @(posedge core_clk_i);
      stop <= 1'b0;
   endtask
   task automatic pop(input logic [11:0] exp);
      chk_b(ov, 1'b1);
      chk_w(ow, exp);
      @(posedge core_clk_i);
      rdy <= 1'b1;
      @(posedge core_clk_i);
      rdy <= 1'b0;
      @(negedge core_clk_i);
   endtask
   // output steal: latch, read timing, rewrite and device strobe
   task automatic s_output;
      @(posedge core_clk_i);
      mem[12'h5A3] <= 12'hC3C;
      cbase = capt_cnt;
      issue(12'h5A3, 12'h000, 1'b0, 1'b1, 1'b0, 1'b0);
      await(0, 2000, n);
      chk_w(cal, 12'h5A3);
      chk_b(act, 1'b1);
      chk_b(p1, 1'b1);
      chk_b(rd, 1'b1);
      chk_b(cpu_hold, 1'b1);
      await(5, 400, n);
      chk_n(n, PH2_NS / CLK_NS);
      await(1, 400, n);
      chk_n(n, (PH3_NS - PH2_NS) / CLK_NS);
      chk_w(cwl, 12'hC3C);
      // wipe the cell after the read: only the rewrite can restore it
      @(posedge core_clk_i);
      mem[12'h5A3] <= 12'h000;
      await(2, 400, n);
      chk_w(mem[12'h5A3], 12'hC3C);
      chk_b(cpu_hold, 1'b0);
      chk_w(cwl, 12'hC3C);
      await(3, 400, n);
      chk_w(capt, 12'hC3C);
      pop(12'hC3C);
   endtask
   // input steal held off until the instruction completes
   task automatic s_input;
      @(posedge core_clk_i);
      insn_b <= 1'b0;
      issue(12'h0FF, 12'h9A5, 1'b1, 1'b1, 1'b0, 1'b0);
      quiet(1000);
      @(posedge core_clk_i);
      insn_b <= 1'b1;
      await(0, 1000, n);
      chk_w(cal, 12'h0FF);
      await(1, 400, n);
      chk_w(cwl, 12'h9A5);
      await(2, 400, n);
      chk_w(mem[12'h0FF], 12'h9A5);
      chk_b(ov, 1'b0);
   endtask
   // increment at the top value wraps to zero, nothing is pushed
   task automatic s_bump;
      @(posedge core_clk_i);
      mem[12'hFFF] <= 12'hFFF;
      issue(12'hFFF, 12'h000, 1'b0, 1'b1, 1'b1, 1'b0);
      await(0, 2000, n);
      await(1, 400, n);
      chk_w(cwl, 12'h000);
      await(2, 400, n);
      chk_w(mem[12'hFFF], 12'h000);
      chk_b(ov, 1'b0);
   endtask
   // three-cycle kind is flagged and never served here
   task automatic s_tally;
      issue(12'h020, 12'h000, 1'b1, 1'b0, 1'b0, 1'b0);
      await(4, 20, n);
      chk_b(tally, 1'b1);
      quiet(1200);
      pulse_stop();
   endtask
   // held request: successive steals, spaced by the rate gap, fill the buffer
   task automatic s_follow;
      @(posedge core_clk_i);
      mem[12'h010] <= 12'h111;
      mem[12'h011] <= 12'h222;
      issue(12'h010, 12'h000, 1'b0, 1'b1, 1'b0, 1'b1);
      await(0, 2000, n);
      chk_w(cal, 12'h010);
      await(0, 1000, n);
      chk_n(n, 2 * CYCLE_CLKS);
      chk_w(cal, 12'h011);
      pulse_stop();
      await(2, 800, n);
      quiet(1200);
   endtask
   // full buffer holds off an output steal until the receiver takes one word from it
   task automatic s_full;
      @(posedge core_clk_i);
      mem[12'h030] <= 12'h333;
      issue(12'h030, 12'h000, 1'b0, 1'b1, 1'b0, 1'b0);
      quiet(1000);
      pop(12'h111);
      await(0, 1000, n);
      chk_w(cal, 12'h030);
      await(2, 400, n);
      pop(12'h222);
      pop(12'h333);
      chk_b(ov, 1'b0);
   endtask
   // reset, then the scenarios in turn
   initial begin
      foreach (mem[i])
         mem[i] = 12'h000;
      {rst_n_i, go, stop, hold, dir, bump, rdy} = 7'h00;
      {insn_b, kind} = 2'b11;
      {addr, data, rdata} = 36'h000000000;
      num_errors = 0;
      total_checks = 0;
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      s_output();
      s_input();
      s_bump();
      s_tally();
      s_follow();
      s_full();
      close_out();
   end
endmodule
